// [edi_dispatcher.sv]
`timescale 1ns/10ps
module edi_dispatcher import edi_pkg::*; #(
  parameter int QUEUE_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Motion conditions, same clock
  input wire edi_motion_t motion_in,
  // Pins: inputs and limit switches, active low
  input wire logic [NUM_INPUTS-1:0] din_n_in,
  input wire logic limit_fwd_n_in,
  input wire logic limit_rev_n_in,
  // Network handle state
  input wire logic [5:0] handle_udp_in,
  input wire logic [5:0] handle_init_in,
  // Packet byte stream
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output edi_byte_t tx_out,
  output logic [2:0] tx_handle_out,
  // Interrupt
  output logic irq_out
);

  localparam int NPIN = NUM_INPUTS + 2;

  logic [15:0] event_mask;
  logic [7:0] input_trigger_mask;
  logic [7:0] net_handle_select;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [NPIN-1:0] pin_s1, pin_s2, pin_s3, pin_level, pin_raw;
  logic [NUM_SRC-1:0] cond, cond_prev, arm, occur, pending, take;
  logic [7:0] push_code;
  logic push, pop, q_full, q_empty, handle_ok, handle_err, sent;
  logic [$clog2(QUEUE_DEPTH):0] q_level;
  logic [7:0] q_head;
  logic wr_en, rd_setup, mask_wr, flush, addr_ok, handle_wr_ok;
  logic [IRQ_WIDTH-1:0] irq_event;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign pready_out = 1'b1;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  assign mask_wr = wr_en && paddr_in == OFF_EVENT_MASK;
  assign flush = mask_wr && pwdata_in[15:0] == 16'h0000;
  assign handle_wr_ok = pwdata_in[7:0] == HANDLE_OFF || pwdata_in[7:0] < HANDLE_COUNT;

  always_comb begin
    unique case (paddr_in)
      OFF_EVENT_MASK, OFF_INPUT_MASK, OFF_QUEUE_LEVEL, OFF_IRQ_STATUS, OFF_IRQ_MASK: addr_ok = 1'b1;
      OFF_HANDLE_SEL: addr_ok = !pwrite_in || handle_wr_ok;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr_out = psel_in && penable_in && !addr_ok;

  // Read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= '0;
    end else if (rd_setup) begin
      unique case (paddr_in)
        OFF_EVENT_MASK: prdata_out <= {16'h0000, event_mask};
        OFF_INPUT_MASK: prdata_out <= {24'h000000, input_trigger_mask};
        OFF_HANDLE_SEL: prdata_out <= {24'h000000, net_handle_select};
        OFF_QUEUE_LEVEL: prdata_out <= 32'(q_level);
        OFF_IRQ_STATUS: prdata_out <= 32'(irq_status);
        OFF_IRQ_MASK: prdata_out <= 32'(irq_mask);
        default: prdata_out <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Arming registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      event_mask <= EVENT_MASK_RST;
    end else if (mask_wr) begin
      event_mask <= pwdata_in[15:0];
    end else begin
      event_mask[BIT_POSERR] <= event_mask[BIT_POSERR] && !occur[2];
      event_mask[BIT_LIMIT] <= event_mask[BIT_LIMIT] && !occur[3];
      event_mask[BIT_INPUT] <= event_mask[BIT_INPUT] && !(|occur[NUM_SRC-1:NUM_MOTION_SRC]);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      input_trigger_mask <= INPUT_MASK_RST;
      net_handle_select <= HANDLE_OFF;
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_en) begin
      if (paddr_in == OFF_INPUT_MASK) begin
        input_trigger_mask <= pwdata_in[7:0];
      end
      if (paddr_in == OFF_HANDLE_SEL && handle_wr_ok) begin
        net_handle_select <= pwdata_in[7:0];
      end
      if (paddr_in == OFF_IRQ_MASK) begin
        irq_mask <= pwdata_in[IRQ_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {limit_rev_n_in, limit_fwd_n_in, din_n_in};
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        pin_s1[i] <= 1'b1;
        pin_s2[i] <= 1'b1;
        pin_s3[i] <= 1'b1;
        pin_level[i] <= 1'b1;
      end else begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i]) begin
          pin_level[i] <= pin_s3[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Conditions and arming
  // ----------------------------------------------------------------
  assign cond[0] = motion_in.axis_done;
  assign cond[1] = motion_in.all_done;
  assign cond[2] = motion_in.pos_err;
  assign cond[3] = motion_in.profiling && ((!pin_level[NUM_INPUTS] && motion_in.dir_fwd)
                   || (!pin_level[NUM_INPUTS+1] && !motion_in.dir_fwd));
  assign cond[4] = motion_in.prog_stopped;
  assign arm[0] = event_mask[BIT_AXIS];
  assign arm[1] = event_mask[BIT_ALL];
  assign arm[2] = event_mask[BIT_POSERR];
  assign arm[3] = event_mask[BIT_LIMIT];
  assign arm[4] = event_mask[BIT_PROG];

  for (genvar k = 0; k < NUM_INPUTS; k++) begin : g_in
    assign cond[NUM_MOTION_SRC+k] = !pin_level[k];
    assign arm[NUM_MOTION_SRC+k] = event_mask[BIT_INPUT] && input_trigger_mask[k];
  end

  // Only a new occurrence counts; an event mask write re-arms so a standing level fires
  assign occur = cond & ~cond_prev & arm;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond_prev <= '0;
    end else if (mask_wr) begin
      cond_prev <= '0;
    end else begin
      cond_prev <= cond;
    end
  end

  // ----------------------------------------------------------------
  // Pending sources, drained lowest index first
  // ----------------------------------------------------------------
  function automatic logic [7:0] code_of(input int idx);
    logic [7:0] code;
    code = CODE_INPUT_BASE + 8'(idx - NUM_MOTION_SRC + 1);
    if (idx == 0) code = CODE_AXIS;
    if (idx == 1) code = CODE_ALL;
    if (idx == 2) code = CODE_POSERR;
    if (idx == 3) code = CODE_LIMIT;
    if (idx == 4) code = CODE_PROG;
    return code;
  endfunction : code_of

  always_comb begin
    take = '0;
    push_code = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        take = NUM_SRC'(1) << i;
        push_code = code_of(i);
      end
    end
  end

  // A full queue stalls here; pending keeps one occurrence per source while it drains
  assign push = |pending && !q_full;

  // New occurrence wins over the take in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pending <= '0;
    end else if (flush) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~(push ? take : '0)) | occur;
    end
  end

  edi_queue #(
    .WIDTH(8),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .push_in(push),
    .push_data_in(push_code),
    .flush_in(flush),
    .pop_in(pop),
    .head_out(q_head),
    .count_out(q_level),
    .full_out(q_full),
    .empty_out(q_empty)
  );

  // ----------------------------------------------------------------
  // Handle check and dispatch
  // ----------------------------------------------------------------
  assign handle_ok = net_handle_select < HANDLE_COUNT
                     && handle_udp_in[net_handle_select[2:0]]
                     && handle_init_in[net_handle_select[2:0]];
  assign handle_err = net_handle_select < HANDLE_COUNT && !handle_ok && !q_empty;
  assign tx_handle_out = net_handle_select[2:0];

  edi_packetizer u_pkt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(5'(q_level)),
    .head_in(q_head),
    .send_ok_in(handle_ok),
    .abort_in(flush),
    .pop_out(pop),
    .tx_ready_in(tx_ready_in),
    .tx_valid_out(tx_valid_out),
    .tx_out(tx_out),
    .sent_out(sent)
  );

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign irq_event[IRQ_SENT] = sent;
  assign irq_event[IRQ_HANDLE_ERR] = handle_err;
  assign irq_event[IRQ_BACKLOG] = q_full && |pending;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status <= '0;
    end else if (wr_en && paddr_in == OFF_IRQ_STATUS) begin
      irq_status <= (irq_status & ~pwdata_in[IRQ_WIDTH-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_MASK_WRITE: assert property (
    mask_wr |=> event_mask == $past(pwdata_in[15:0]))
    else $error("event mask did not take written value");
  AST_FLUSH: assert property (
    flush |=> q_level == '0 && pending == '0 && !tx_valid_out)
    else $error("mask zero left queue or packet alive");
  AST_AXIS_CODE: assert property (
    occur[0] && !q_full && !flush |=> ##[0:13] (push && push_code == CODE_AXIS))
    else $error("axis complete byte not queued");
  AST_ONESHOT: assert property (
    occur[2] && !mask_wr |=> !event_mask[BIT_POSERR])
    else $error("position error stayed armed");
  AST_INPUT_GATE: assert property (
    |occur[NUM_SRC-1:NUM_MOTION_SRC] |-> event_mask[BIT_INPUT])
    else $error("input fired without bit 15");
  AST_LIMIT_DIR: assert property (
    occur[3] |-> motion_in.profiling)
    else $error("limit fired while not profiling");
  AST_HANDLE_GATE: assert property (
    $rose(tx_valid_out) |-> $past(handle_ok))
    else $error("packet sent on disabled handle");
  AST_HEADER: assert property (
    $rose(tx_valid_out) |-> tx_out.data == PKT_HEADER && !tx_out.last)
    else $error("packet without header");
  AST_FOOTER: assert property (
    tx_valid_out && tx_out.last |-> tx_out.data >= 8'h03 && tx_out.data <= 8'h12)
    else $error("byte count out of range");
  AST_HANDLE_ERR: assert property (
    handle_err |=> irq_status[IRQ_HANDLE_ERR])
    else $error("handle error not flagged");
  AST_QUERY: assert property (
    psel_in && penable_in && !pwrite_in && paddr_in == OFF_EVENT_MASK
      |-> prdata_out[15:0] == $past(event_mask))
    else $error("mask query mismatch");

  COV_PACKET: cover property (sent);
  COV_INPUT: cover property (|occur[NUM_SRC-1:NUM_MOTION_SRC] ##[1:20] push);
  COV_BACKLOG: cover property (q_full && |pending);
  COV_FLUSH_BUSY: cover property (flush && tx_valid_out);

endmodule : edi_dispatcher

// [edi_pkg.sv]
package edi_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_EVENT_MASK = 8'h00;
  localparam logic [7:0] OFF_INPUT_MASK = 8'h04;
  localparam logic [7:0] OFF_HANDLE_SEL = 8'h08;
  localparam logic [7:0] OFF_QUEUE_LEVEL = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] EVENT_MASK_RST = 16'h0000;
  localparam logic [7:0] INPUT_MASK_RST = 8'h00;
  localparam logic [7:0] HANDLE_OFF = 8'hff;
  localparam logic [7:0] HANDLE_COUNT = 8'h06;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Event mask bit positions and status byte codes
  // ----------------------------------------------------------------
  localparam int BIT_AXIS = 0;
  localparam int BIT_ALL = 8;
  localparam int BIT_POSERR = 9;
  localparam int BIT_LIMIT = 10;
  localparam int BIT_PROG = 13;
  localparam int BIT_INPUT = 15;
  localparam logic [7:0] CODE_AXIS = 8'hd0;
  localparam logic [7:0] CODE_ALL = 8'hd8;
  localparam logic [7:0] CODE_POSERR = 8'hc8;
  localparam logic [7:0] CODE_LIMIT = 8'hc0;
  localparam logic [7:0] CODE_PROG = 8'hdb;
  localparam logic [7:0] CODE_INPUT_BASE = 8'he0;
  localparam int NUM_INPUTS = 8;
  localparam int NUM_MOTION_SRC = 5;
  localparam int NUM_SRC = NUM_MOTION_SRC + NUM_INPUTS;

  // ----------------------------------------------------------------
  // Packet framing
  // ----------------------------------------------------------------
  localparam logic [7:0] PKT_HEADER = 8'h01;
  localparam logic [7:0] PKT_OVERHEAD = 8'h02;
  localparam int PKT_MAX_STATUS = 16;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_SENT = 0;
  localparam int IRQ_HANDLE_ERR = 1;
  localparam int IRQ_BACKLOG = 2;
  localparam int IRQ_WIDTH = 3;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } edi_byte_t;

  typedef struct packed {
    logic axis_done;
    logic all_done;
    logic pos_err;
    logic prog_stopped;
    logic profiling;
    logic dir_fwd;
  } edi_motion_t;

  typedef enum {PKT_IDLE, PKT_HEAD, PKT_BODY, PKT_FOOT} edi_pkt_state_t;

endpackage : edi_pkg

// [edi_queue.sv]
`timescale 1ns/10ps
module edi_queue import edi_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Fill side
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic flush_in,
  // Drain side
  input wire logic pop_in,
  output logic [WIDTH-1:0] head_out,
  output logic [$clog2(DEPTH):0] count_out,
  output logic full_out,
  output logic empty_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic do_push;
  logic do_pop;

  assign full_out = count_out == (AW+1)'(DEPTH);
  assign empty_out = count_out == '0;
  assign do_push = push_in && !full_out;
  assign do_pop = pop_in && !empty_out;
  assign head_out = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  // Flush drops everything, including a push in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_out <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_out <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
      end
      if (do_pop) begin
        rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
      end
      count_out <= count_out + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule : edi_queue

// [edi_packetizer.sv]
`timescale 1ns/10ps
module edi_packetizer import edi_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Queue side
  input wire logic [4:0] level_in,
  input wire logic [7:0] head_in,
  input wire logic send_ok_in,
  input wire logic abort_in,
  output logic pop_out,
  // Byte stream
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output edi_byte_t tx_out,
  output logic sent_out
);

  edi_pkt_state_t state;
  logic [4:0] remaining;
  logic [4:0] total;
  logic fire;

  assign tx_valid_out = state != PKT_IDLE;
  assign fire = tx_valid_out && tx_ready_in;
  assign pop_out = fire && (state == PKT_HEAD || state == PKT_BODY) && remaining != '0;
  assign sent_out = fire && state == PKT_FOOT;

  // Abort drops the frame mid-way; the sink must discard an unterminated one
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= PKT_IDLE;
      remaining <= '0;
      total <= '0;
      tx_out <= '0;
    end else if (abort_in) begin
      state <= PKT_IDLE;
      remaining <= '0;
      tx_out <= '0;
    end else begin
      unique case (state)
        PKT_IDLE: begin
          if (send_ok_in && level_in != '0) begin
            total <= (level_in > 5'(PKT_MAX_STATUS)) ? 5'(PKT_MAX_STATUS) : level_in;
            remaining <= (level_in > 5'(PKT_MAX_STATUS)) ? 5'(PKT_MAX_STATUS) : level_in;
            tx_out <= '{data: PKT_HEADER, last: 1'b0};
            state <= PKT_HEAD;
          end
        end
        PKT_HEAD, PKT_BODY: begin
          if (fire && remaining != '0) begin
            tx_out <= '{data: head_in, last: 1'b0};
            remaining <= remaining - 5'h01;
            state <= PKT_BODY;
          end else if (fire) begin
            tx_out <= '{data: {3'h0, total} + PKT_OVERHEAD, last: 1'b1};
            state <= PKT_FOOT;
          end
        end
        PKT_FOOT: begin
          if (fire) begin
            tx_out <= '0;
            state <= PKT_IDLE;
          end
        end
      endcase
    end
  end

endmodule : edi_packetizer

// [edi_host_model.sv]
`timescale 1ns/10ps
module edi_host_model import edi_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pace control
  input wire logic slow_in,
  // Byte stream
  input wire logic tx_valid_in,
  input wire edi_byte_t tx_in,
  output logic tx_ready_out
);
  logic [8:0] got[$];
  logic [1:0] div;
  // Slow mode takes one byte in four to stretch every frame
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div <= 2'h0;
      tx_ready_out <= 1'b0;
    end else begin
      div <= div + 2'h1;
      tx_ready_out <= !slow_in || div == 2'h3;
      if (tx_valid_in && tx_ready_out) begin
        got.push_back(tx_in);
      end
    end
  end
endmodule : edi_host_model

// [tb.sv]
`timescale 1ns/10ps
module tb import edi_pkg::*;;
  logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0] paddr = 8'h00, din_n = 8'hff, sel;
  logic [31:0] pwdata = 32'h0, r;
  logic x, lim_f = 1, lim_r = 1, pready_out, pslverr_out, tx_valid, tx_ready, irq_out;
  logic [31:0] prdata_out;
  edi_motion_t motion = '0;
  edi_byte_t tx;
  logic [2:0] tx_handle;
  // Handle 0 usable, 1 not UDP, 2 not initialised
  logic [5:0] h_udp = 6'h05, h_init = 6'h03;
  logic [7:0] cap_q[$];
  logic [8:0] exp_q[$];
  int err_count = 0, cmp_count = 0, cycles = 0, n;
  int seed = 32'h2dfad15a;
  always #20 clk_in = ~clk_in;
  edi_dispatcher edi_dispatcher_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .prdata_out(prdata_out), .motion_in(motion), .din_n_in(din_n),
    .limit_fwd_n_in(lim_f), .limit_rev_n_in(lim_r), .handle_udp_in(h_udp), .handle_init_in(h_init),
    .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_out(tx), .tx_handle_out(tx_handle), .irq_out(irq_out));
  edi_host_model host_i (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow), .tx_valid_in(tx_valid),
    .tx_in(tx), .tx_ready_out(tx_ready));
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    cmp_count++;
    if (seen !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_in);
    penable <= 1;
    // Ends once pready_out is high, which the dispatcher always drives
    do @(posedge clk_in); while (pready_out !== 1'b1);
    r = prdata_out;
    x = pslverr_out;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    check("rdata", r, e);
  endtask : rd
  task automatic pulse(input edi_motion_t m);
    @(posedge clk_in);
    motion <= m;
    repeat (3) @(posedge clk_in);
    motion <= '0;
    repeat (6) @(posedge clk_in);
  endtask : pulse
  // ----------------------------------------------------------------
  // Reference model: header, status bytes, count footer
  // ----------------------------------------------------------------
  task automatic model_pkt(input logic [7:0] s[$]);
    exp_q.push_back({PKT_HEADER, 1'b0});
    foreach (s[i]) exp_q.push_back({s[i], 1'b0});
    exp_q.push_back({8'(s.size() + 2), 1'b1});
  endtask : model_pkt
  task automatic cmp_pkts();
    int k;
    k = 0;
    while (host_i.got.size() < exp_q.size() && k < 400) begin
      @(posedge clk_in);
      k++;
    end
    repeat (8) @(posedge clk_in);
    check("pkt_len", host_i.got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < host_i.got.size()) check("pkt_byte", {23'h0, host_i.got[i]}, {23'h0, exp_q[i]});
    host_i.got.delete();
    exp_q = {};
  endtask : cmp_pkts
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 0;
    rd(OFF_EVENT_MASK, 0);
    rd(OFF_INPUT_MASK, 0);
    rd(OFF_HANDLE_SEL, 32'hff);
    rd(OFF_IRQ_MASK, 0);
    apb(0, 8'h18, 0);
    check("unmapped_err", x, 1);
    apb(1, OFF_HANDLE_SEL, 6);
    check("handle_err", x, 1);
    rd(OFF_HANDLE_SEL, 32'hff);
    // ----------------------------------------------------------------
    // Five events in one cycle, held back while transmission is off
    // ----------------------------------------------------------------
    lim_f <= 0;
    repeat (8) @(posedge clk_in);
    apb(1, OFF_EVENT_MASK, 32'h2701);
    pulse(6'h3f);
    lim_f <= 1;
    rd(OFF_QUEUE_LEVEL, 5);
    rd(OFF_EVENT_MASK, 32'h2101);
    slow <= 1;
    apb(1, OFF_HANDLE_SEL, 0);
    model_pkt('{CODE_AXIS, CODE_ALL, CODE_POSERR, CODE_LIMIT, CODE_PROG});
    cmp_pkts();
    check("handle_out", tx_handle, 0);
    rd(OFF_IRQ_STATUS, 1);
    slow <= 0;
    apb(1, OFF_EVENT_MASK, 32'h0001);
    pulse(6'h10);
    pulse(6'h20);
    model_pkt('{CODE_AXIS});
    cmp_pkts();
    // ----------------------------------------------------------------
    // Eighteen events back up the queue; first packet caps at sixteen
    // ----------------------------------------------------------------
    apb(1, OFF_HANDLE_SEL, 32'hff);
    apb(1, OFF_EVENT_MASK, 32'h2101);
    repeat (6) pulse(6'h34);
    rd(OFF_QUEUE_LEVEL, 16);
    rd(OFF_IRQ_STATUS, 5);
    for (int i = 0; i < PKT_MAX_STATUS; i++) begin
      cap_q.push_back(i % 3 == 0 ? CODE_AXIS : (i % 3 == 1 ? CODE_ALL : CODE_PROG));
    end
    model_pkt(cap_q);
    model_pkt('{CODE_ALL, CODE_PROG});
    apb(1, OFF_HANDLE_SEL, 0);
    cmp_pkts();
    // ----------------------------------------------------------------
    // One selected input low beside an unselected one
    // ----------------------------------------------------------------
    n = 1 + ($unsigned($random(seed)) % 8);
    sel = 8'h01 << (n - 1);
    apb(1, OFF_INPUT_MASK, sel);
    apb(1, OFF_EVENT_MASK, 32'h8000);
    @(posedge clk_in);
    din_n <= ~(sel | {sel[6:0], sel[7]});
    repeat (12) @(posedge clk_in);
    din_n <= 8'hff;
    model_pkt('{CODE_INPUT_BASE + 8'(n)});
    cmp_pkts();
    rd(OFF_EVENT_MASK, 0);
    rd(OFF_INPUT_MASK, {24'h0, sel});
    // ----------------------------------------------------------------
    // Bad handle, interrupt, flush by zero mask
    // ----------------------------------------------------------------
    apb(1, OFF_HANDLE_SEL, 1);
    apb(1, OFF_IRQ_STATUS, 7);
    apb(1, OFF_EVENT_MASK, 1);
    pulse(6'h20);
    rd(OFF_QUEUE_LEVEL, 1);
    rd(OFF_IRQ_STATUS, 2);
    check("irq_off", irq_out, 0);
    apb(1, OFF_IRQ_MASK, 2);
    @(posedge clk_in);
    check("irq_on", irq_out, 1);
    apb(1, OFF_EVENT_MASK, 0);
    rd(OFF_QUEUE_LEVEL, 0);
    pulse(6'h20);
    rd(OFF_QUEUE_LEVEL, 0);
    apb(1, OFF_IRQ_STATUS, 7);
    rd(OFF_IRQ_STATUS, 0);
    check("irq_clr", irq_out, 0);
    // ----------------------------------------------------------------
    // Limit direction, uninitialised handle
    // ----------------------------------------------------------------
    apb(1, OFF_HANDLE_SEL, 2);
    lim_r <= 0;
    repeat (8) @(posedge clk_in);
    apb(1, OFF_EVENT_MASK, 32'h0400);
    pulse(6'h03);
    rd(OFF_QUEUE_LEVEL, 0);
    pulse(6'h02);
    rd(OFF_QUEUE_LEVEL, 1);
    rd(OFF_EVENT_MASK, 0);
    rd(OFF_IRQ_STATUS, 2);
    check("irq_err", irq_out, 1);
    check("no_pkt", host_i.got.size(), 0);
    close_out();
  end
endmodule : tb
